/* File: pgc_pkg.sv */
// package for the second pll general control register bank
`default_nettype none
package pgc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] PGC_ADDR_GENERAL = 16'h0200;
  localparam logic [15:0] PGC_ADDR_CPUMP = 16'h0201;
  localparam logic [15:0] PGC_ADDR_REFDIV = 16'h0202;
  localparam logic [15:0] PGC_ADDR_UPDATE = 16'h0005;
  localparam int GEN_XTAL_BIT = 4;
  localparam int GEN_SYNC_BIT = 2;
  localparam int GEN_CAL_BIT = 1;
  localparam int GEN_PD_BIT = 0;
  localparam int CP_MAN_BIT = 3;
  localparam int UPD_BIT = 0;
  localparam logic [7:0] GEN_MASK = 8'h17;
  localparam logic [7:0] CPUMP_MASK = 8'h0F;
  localparam logic [7:0] REFDIV_MASK = 8'h0F;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [3:0] REFDIV_ZERO_CODE = 4'h0;
  localparam logic [4:0] REFDIV_ZERO_RATIO = 5'h10;
  localparam int CP_STEP_UA = 125;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pgc_req_s;
  typedef struct packed {
    logic xtal_en;
    logic pll_pd;
    logic cp_manual;
    logic [9:0] cp_current_ua;
    logic [4:0] ref_div_ratio;
  } pgc_ctrl_s;
endpackage
`default_nettype wire

/* File: pgc_regs.sv */
// second pll general control register bank with update transfer
//
// Summary of operation
// - xtal bit selects crystal amp or differential input
// - sync arms on 1, fires on falling edge
// - calibrate bit set starts vco calibration
// - power-down bit powers whole pll down
// - manual enable picks manual or automatic current
// - current field ignored while manual enable clear
// - manual current equals 125 uA times code+1
// - divider field zero divides by sixteen
// - divider field 1..15 divides by value
// - writes take effect on update register bit0
`default_nettype none
module pgc_regs
  import pgc_pkg::*;
#(
  // microamps per step of the manual current code
  parameter int CP_STEP = CP_STEP_UA
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire pgc_req_s req,
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  output logic sync_pulse_q,
  output logic cal_start_q,
  output var pgc_ctrl_s ctrl_q
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // eight steps must fit the ten-bit current field of the control word
  if (CP_STEP < 1 || CP_STEP * 8 > 1023)
  begin : g_bad_step
    $error("current step does not fit the current field");
  end

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  // requests come from logic on this clock, so no synchroniser is needed
  logic wr_gen;
  logic wr_cp;
  logic wr_refdiv;
  logic upd;

  // unmapped writes match no decode and are dropped
  assign wr_gen = req.wr && req.addr == PGC_ADDR_GENERAL;
  assign wr_cp = req.wr && req.addr == PGC_ADDR_CPUMP;
  assign wr_refdiv = req.wr && req.addr == PGC_ADDR_REFDIV;
  // the update register stores nothing; a write with bit 0 set is the event
  assign upd = req.wr && req.addr == PGC_ADDR_UPDATE && req.wdata[UPD_BIT];

  // ----------------------------------------
  // shadow registers (host writes land here)
  // ----------------------------------------
  // general: crystal amp bit 4, sync bit 2, calibrate bit 1, power-down bit 0
  // charge pump: manual enable bit 3, current code bits 2..0
  // reference divider: ratio code bits 3..0
  // masking keeps unused and reserved bits at zero
  // reset leaves all zero: differential input, automatic current
  logic [7:0] gen_sh_q;
  logic [7:0] cp_sh_q;
  logic [7:0] rd_sh_q;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      gen_sh_q <= RESET_VAL;
    else if (wr_gen)
      gen_sh_q <= req.wdata & GEN_MASK;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      cp_sh_q <= RESET_VAL;
    else if (wr_cp)
      cp_sh_q <= req.wdata & CPUMP_MASK;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rd_sh_q <= RESET_VAL;
    else if (wr_refdiv)
      rd_sh_q <= req.wdata & REFDIV_MASK;
  end

  // ----------------------------------------
  // active registers, loaded on update
  // ----------------------------------------
  // the analog side only ever sees a complete set of values;
  // a write and an update in one cycle copy the older shadow value
  logic [7:0] gen_act_q;
  logic [7:0] cp_act_q;
  logic [7:0] rd_act_q;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      gen_act_q <= RESET_VAL;
    else if (upd)
      gen_act_q <= gen_sh_q;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      cp_act_q <= RESET_VAL;
    else if (upd)
      cp_act_q <= cp_sh_q;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rd_act_q <= RESET_VAL;
    else if (upd)
      rd_act_q <= rd_sh_q;
  end

  // ----------------------------------------
  // strobes from active bit transitions
  // ----------------------------------------
  // edges are taken on the active copy so a strobe follows the update;
  // a bit set and cleared between two updates gives no strobe
  logic [7:0] gen_d;
  logic sync_fall;
  logic cal_rise;

  assign gen_d = upd ? gen_sh_q : gen_act_q;
  assign sync_fall = gen_act_q[GEN_SYNC_BIT] && !gen_d[GEN_SYNC_BIT];
  assign cal_rise = !gen_act_q[GEN_CAL_BIT] && gen_d[GEN_CAL_BIT];

  // strobes last one cycle; an update with no new edge gives none
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      sync_pulse_q <= 1'b0;
    else
      sync_pulse_q <= sync_fall;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      cal_start_q <= 1'b0;
    else
      cal_start_q <= cal_rise;
  end

  // ----------------------------------------
  // decoded controls
  // ----------------------------------------
  // automatic mode reports zero current; the analog loop owns it then
  logic [9:0] cp_ua;
  logic [4:0] ratio;

  assign cp_ua = 10'(CP_STEP) * ({7'h00, cp_act_q[2:0]} + 10'h001);
  // code zero is the longest division, so the ratio is one bit wider
  always_comb
  begin
    if (rd_act_q[3:0] == REFDIV_ZERO_CODE)
      ratio = REFDIV_ZERO_RATIO;
    else
      ratio = {1'b0, rd_act_q[3:0]};
  end

  // registered so every control leaves the bank straight from a flip-flop
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      ctrl_q <= '0;
    else
    begin
      ctrl_q.xtal_en <= gen_act_q[GEN_XTAL_BIT];
      ctrl_q.pll_pd <= gen_act_q[GEN_PD_BIT];
      ctrl_q.cp_manual <= cp_act_q[CP_MAN_BIT];
      ctrl_q.cp_current_ua <= cp_act_q[CP_MAN_BIT] ? cp_ua : 10'h000;
      ctrl_q.ref_div_ratio <= ratio;
    end
  end

  // ----------------------------------------
  // read port, one cycle latency
  // ----------------------------------------
  // reads return the written copy, so software sees a value before update
  logic [7:0] rd_mux;

  always_comb
  begin
    unique case (req.addr)
      PGC_ADDR_GENERAL: rd_mux = gen_sh_q;
      PGC_ADDR_CPUMP: rd_mux = cp_sh_q;
      PGC_ADDR_REFDIV: rd_mux = rd_sh_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // rvalid marks the cycle in which rdata_q holds the value addressed by the read
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rvalid_q <= 1'b0;
    else
      rvalid_q <= req.rd;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= 8'h00;
    else
      rdata_q <= rd_mux;
  end
endmodule
`default_nettype wire

/* File: pgc_regs_sva.sv */
// assertions for the pll control register bank
`default_nettype none
module pgc_chk
  import pgc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire pgc_req_s req,
  input wire logic [7:0] rdata_q,
  input wire logic rvalid_q,
  input wire logic sync_pulse_q,
  input wire logic cal_start_q,
  input wire pgc_ctrl_s ctrl_q
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  wire logic up = req.wr && req.addr == PGC_ADDR_UPDATE && req.wdata[0];
  wire logic mp = req.addr inside {PGC_ADDR_GENERAL, PGC_ADDR_CPUMP, PGC_ADDR_REFDIV};
  sequence s_one(x);
    x ##1 !x;
  endsequence
  property p_xt; $changed(ctrl_q.xtal_en) |-> $past(up, 2); endproperty
  property p_pd; $changed(ctrl_q.pll_pd) |-> $past(up, 2); endproperty
  property p_au; !ctrl_q.cp_manual |-> ctrl_q.cp_current_ua == 0; endproperty
  property p_ma;
    ctrl_q.cp_manual |-> ctrl_q.cp_current_ua % CP_STEP_UA == 0 &&
      ctrl_q.cp_current_ua inside {[CP_STEP_UA:8 * CP_STEP_UA]};
  endproperty
  property p_cm; $changed(ctrl_q.cp_manual) |-> $past(up, 2); endproperty
  property p_su; sync_pulse_q || cal_start_q |-> $past(up); endproperty
  property p_dv; $past(rstn) |-> ctrl_q.ref_div_ratio inside {[1:16]}; endproperty
  property p_rd; req.rd && !mp |=> rvalid_q && rdata_q == 0; endproperty
  property p_sy; sync_pulse_q |-> s_one(sync_pulse_q); endproperty
  property p_ca; cal_start_q |-> s_one(cal_start_q); endproperty
  a_xt: assert property (p_xt) else $error("xtal moved without update");
  a_pd: assert property (p_pd) else $error("pd moved without update");
  a_au: assert property (p_au) else $error("auto current not zero");
  a_ma: assert property (p_ma) else $error("manual current off step");
  a_dv: assert property (p_dv) else $error("divider ratio out of range");
  a_rd: assert property (p_rd) else $error("unmapped read not zero");
  a_sy: assert property (p_sy) else $error("sync pulse too long");
  a_ca: assert property (p_ca) else $error("cal pulse too long");
  a_cm: assert property (p_cm) else $error("manual mode moved without update");
  a_su: assert property (p_su) else $error("strobe without update");
endmodule
bind pgc_regs pgc_chk pgc_chk_inst (
  .core_clk(core_clk),
  .rstn(rstn),
  .req(req),
  .rdata_q(rdata_q),
  .rvalid_q(rvalid_q),
  .sync_pulse_q(sync_pulse_q),
  .cal_start_q(cal_start_q),
  .ctrl_q(ctrl_q)
);
`default_nettype wire

/* File: second_pll_general_control_regs_tb.sv */
// testbench for the pll control register bank
`default_nettype none
`define CK(a,b) begin n_compared++; if ((a)!==(b)) begin num_errors++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module second_pll_general_control_regs_tb import pgc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rstn = 0, rvalid_q, sync_pulse_q, cal_start_q;
  logic [7:0] rdata_q, v;
  pgc_req_s req = '0;
  pgc_ctrl_s ctrl_q;
  int num_errors = 0, n_compared = 0, ns = 0, nc = 0;
  pgc_regs pgc_regs_inst (
    .core_clk(core_clk),
    .rstn(rstn),
    .req(req),
    .rdata_q(rdata_q),
    .rvalid_q(rvalid_q),
    .sync_pulse_q(sync_pulse_q),
    .cal_start_q(cal_start_q),
    .ctrl_q(ctrl_q)
  );
  // code zero divides by sixteen, any other code by itself
  function automatic logic [4:0] exp_ratio(logic [3:0] c);
    return (c == 4'h0) ? 5'h10 : {1'b0, c};
  endfunction
  // zero in automatic mode, one step per code plus one in manual mode
  function automatic logic [9:0] exp_ua(logic [3:0] r);
    return r[3] ? 10'(CP_STEP_UA * (int'(r[2:0]) + 1)) : 10'h000;
  endfunction
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) {ns, nc} <= {ns + sync_pulse_q, nc + cal_start_q};
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge core_clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) req.wr <= 0;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    @(posedge core_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk) req.rd <= 0;
    #1 `CK({rvalid_q, rdata_q}, {1'b1, e})
  endtask
  // ctrl_q lags the update by two edges
  task automatic upd();
    wr(PGC_ADDR_UPDATE, 8'h01);
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(99));
    repeat (4) @(posedge core_clk);
    rstn <= 1;
    rd(PGC_ADDR_CPUMP, RESET_VAL);
    `CK(ctrl_q, {1'b0, 1'b0, 1'b0, 10'h000, 5'h10})
    for (int i = 0; i < 16; i++)
    begin
      v = {4'($urandom), 4'(i)};
      wr(PGC_ADDR_REFDIV, v);
      wr(PGC_ADDR_CPUMP, v);
      rd(PGC_ADDR_REFDIV, v & REFDIV_MASK);
      upd();
      `CK(ctrl_q.ref_div_ratio, exp_ratio(v[3:0]))
      `CK(ctrl_q.cp_manual, v[3])
      `CK(ctrl_q.cp_current_ua, exp_ua(v[3:0]))
    end
    $display("divider and current loop done");
    wr(PGC_ADDR_GENERAL, 8'hFF);
    rd(PGC_ADDR_GENERAL, GEN_MASK);
    rd(16'h0203, 8'h00);
    `CK({ctrl_q.xtal_en, ctrl_q.pll_pd}, 2'b00)
    upd();
    `CK({ctrl_q.xtal_en, ctrl_q.pll_pd}, 2'b11)
    for (int k = 0; k < 3; k++)
    begin
      wr(PGC_ADDR_GENERAL, (k == 1) ? 8'h02 : 8'h00);
      upd();
    end
    `CK({ctrl_q.xtal_en, ctrl_q.pll_pd}, 2'b00)
    `CK({ns, nc}, {32'd1, 32'd2})
    $display("general register test done");
    tally_and_finish();
  end
  initial
  begin
    #20us;
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
